// file: hw/serial_eeprom.v
// Purpose: Two-wire serial target of a byte-organised program memory.
// Assumes: ref_clk is far faster than the serial clock; pins are async.
// Notes:   Storage is flip-flops; ADDR_W picks the small or large variant.
//
// Notes on behaviour
// - Small variant: 128 pages, 12-bit address.
// - Large variant: 256 pages, 13-bit address.
// - Protect input high blocks all array writes.
// - Sample on clock rise, drive after fall.
// - Data changes only while clock low.
// - Data falling with clock high is start.
// - Data rising with clock high is stop.
// - Eight-bit words, acknowledged low on ninth clock.
// - Standby at power-up and after stop.
// - Address word holds type code and straps.
// - Address word low bit selects read.
// - Match acknowledges; mismatch returns to standby.
// - Byte write: address, data, stop programs.
// - Ignore the bus while programming runs.
// - Program cycle ends within five milliseconds.
// - Page write takes up to 32 bytes.
// - Page write wraps the low five bits.
// - Polling acknowledged only after programming ends.
// - Counter is last address plus one.
// - Current read sends byte at counter.
// - Sequential read continues while controller acknowledges.
`timescale 1ns/1ns
`include "eeprom_consts.vh"
module serial_eeprom #(
	parameter         ADDR_W      = `ADDR_W_LARGE,
	parameter [3:0]   DEVICE_TYPE = `DEV_TYPE_DEFAULT,
	parameter         PROG_CYCLES = `PROG_CYCLES
) (
	input  wire       ref_clk,
	input  wire       arst_n,
	input  wire       scl_pin,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe_n,
	input  wire       strap_bit_high,
	input  wire       strap_bit_mid,
	input  wire       strap_bit_low,
	input  wire       write_protect,
	output wire       program_busy,
	output reg        standby
);

	// Serial engine states.
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RX   = 3'h1;
	localparam [2:0] ST_ACK  = 3'h2;
	localparam [2:0] ST_TX   = 3'h3;
	localparam [2:0] ST_RACK = 3'h4;

	localparam        MEM_BYTES = 1 << ADDR_W;
	localparam        PAGE_HI_W = ADDR_W - `PAGE_BITS;

	// Address word decode: type code, straps and the busy gate.
	function addr_match;
		input [7:0] word;
		input [2:0] straps;
		input       busy;
		begin
			addr_match = (word[7:4] == DEVICE_TYPE) &&
				(word[3:1] == straps) && !busy;
		end
	endfunction

	wire [5:0] pins_s;
	wire       scl_s;
	wire       sda_s;
	wire [2:0] strap_s;
	wire       wp_s;

	reg        scl_d_reg;
	reg        sda_d_reg;
	reg [2:0]  state_reg;
	reg [1:0]  kind_reg;
	reg [3:0]  bit_cnt_reg;
	reg [7:0]  shift_reg;
	reg [ADDR_W-1:0] addr_reg;
	reg [PAGE_HI_W-1:0] page_reg;
	reg        rw_reg;
	reg        host_ack_reg;
	reg        pend_reg;
	reg        commit_reg;
	reg [`PAGE_BYTES-1:0] mask_reg;
	reg [7:0]  pbuf [0:`PAGE_BYTES-1];
	reg [7:0]  mem [0:MEM_BYTES-1];

	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;
	wire       byte_end;
	wire       data_we;
	wire [7:0] rd_byte;
	wire [ADDR_W-1:0] addr_inc;
	wire [ADDR_W-1:0] page_inc;

	// Every pin passes two flops before any logic sees it.
	pin_sync #(
		.WIDTH     (6),
		.RESET_VAL (`PIN_RESET_VAL)
	) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.pins    ({write_protect, strap_bit_high, strap_bit_mid,
			strap_bit_low, sda_in, scl_pin}),
		.synced  (pins_s)
	);

	assign scl_s   = pins_s[0];
	assign sda_s   = pins_s[1];
	assign strap_s = pins_s[4:2];
	assign wp_s    = pins_s[5];

	// The program cycle timer; its busy flag gates address matching.
	program_timer #(
		.CNT_W  (`PROG_CNT_W),
		.CYCLES (PROG_CYCLES)
	) u_timer (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.start   (commit_reg),
		.busy    (program_busy)
	);

	// One more stage of each line gives the edges of the serial clock.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise  = scl_s && !scl_d_reg;
	assign scl_fall  = !scl_s && scl_d_reg;
	// A data edge with the clock steady high is a bus condition.
	assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
	assign byte_end  = (state_reg == ST_RX) && scl_fall &&
		(bit_cnt_reg == `WORD_BITS);

	// A data byte lands in the page buffer only while unprotected.
	assign data_we   = byte_end && (kind_reg == `KIND_DATA) &&
		!wp_s;

	assign rd_byte   = mem[addr_reg];
	// Reads roll over the whole array by natural wrap of the counter.
	assign addr_inc  = addr_reg + 1'b1;
	// Writes only step the low five bits and hold the page.
	assign page_inc  = {addr_reg[ADDR_W-1:`PAGE_BITS],
		addr_reg[`PAGE_BITS-1:0] + 1'b1};

	// Page buffer holds the bytes of one write until the stop.
	always @(posedge ref_clk) begin
		if (data_we) begin
			pbuf[addr_reg[`PAGE_BITS-1:0]] <= shift_reg;
		end
	end

	// Array update happens once, at the stop that ends a write.
	// Storage is left uninitialised, as a fresh part would be.
	// One process writes the array, so it keeps a single driver.
	integer ci;
	always @(posedge ref_clk) begin
		if (commit_reg) begin
			for (ci = 0; ci < `PAGE_BYTES; ci = ci + 1) begin
				if (mask_reg[ci]) begin
					mem[{page_reg, ci[`PAGE_BITS-1:0]}] <= pbuf[ci];
				end
			end
		end
	end

	// Standby while idle and no program cycle is running or starting.
	// The commit pulse is included so standby drops with busy's rise.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			standby <= 1'b1;
		end else begin
			standby <= (state_reg == ST_IDLE) && !program_busy &&
				!commit_reg;
		end
	end

	// Serial engine: start and stop take priority over bit traffic.
	// Output changes wait for a clock fall, so the line moves only
	// while the clock is low and no false condition can arise.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg    <= ST_IDLE;
			kind_reg     <= `KIND_DEV;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			addr_reg     <= {ADDR_W{1'b0}};
			page_reg     <= {PAGE_HI_W{1'b0}};
			rw_reg       <= 1'b0;
			host_ack_reg <= 1'b0;
			pend_reg     <= 1'b0;
			commit_reg   <= 1'b0;
			mask_reg     <= {`PAGE_BYTES{1'b0}};
			sda_out      <= 1'b0;
			sda_oe_n     <= 1'b1;
		end else begin
			commit_reg <= 1'b0;
			sda_out    <= 1'b0;
			if (start_det) begin
				// A start, repeated or not, drops any unfinished write.
				state_reg   <= ST_RX;
				kind_reg    <= `KIND_DEV;
				bit_cnt_reg <= 4'h0;
				sda_oe_n    <= 1'b1;
				pend_reg    <= 1'b0;
				mask_reg    <= {`PAGE_BYTES{1'b0}};
			end else if (stop_det) begin
				state_reg <= ST_IDLE;
				sda_oe_n  <= 1'b1;
				if (pend_reg) begin
					commit_reg <= 1'b1;
					pend_reg   <= 1'b0;
				end
			end else begin
				case (state_reg)
				ST_RX: begin
					if (scl_rise && bit_cnt_reg < `WORD_BITS) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 1'b1;
					end else if (byte_end) begin
						case (kind_reg)
						`KIND_DEV: begin
							if (addr_match(shift_reg, strap_s,
								program_busy)) begin
								rw_reg    <= shift_reg[0];
								sda_oe_n  <= 1'b0;
								state_reg <= ST_ACK;
							end else begin
								state_reg <= ST_IDLE;
							end
						end
						`KIND_ADDR_HI: begin
							// Bits above the array width are dropped.
							addr_reg[ADDR_W-1:8] <= shift_reg[ADDR_W-9:0];
							sda_oe_n  <= 1'b0;
							state_reg <= ST_ACK;
						end
						`KIND_ADDR_LO: begin
							addr_reg[7:0] <= shift_reg;
							sda_oe_n  <= 1'b0;
							state_reg <= ST_ACK;
						end
						default: begin
							// Protected bytes are still acknowledged.
							sda_oe_n  <= 1'b0;
							state_reg <= ST_ACK;
							addr_reg  <= page_inc;
							if (!wp_s) begin
								page_reg <= addr_reg[ADDR_W-1:`PAGE_BITS];
								mask_reg[addr_reg[`PAGE_BITS-1:0]] <= 1'b1;
								pend_reg <= 1'b1;
							end
						end
						endcase
					end
				end
				ST_ACK: begin
					// The acknowledge is released at the end of clock nine.
					if (scl_fall) begin
						if (kind_reg == `KIND_DEV && rw_reg) begin
							shift_reg   <= rd_byte;
							addr_reg    <= addr_inc;
							sda_oe_n    <= rd_byte[7];
							bit_cnt_reg <= 4'h1;
							state_reg   <= ST_TX;
						end else begin
							sda_oe_n    <= 1'b1;
							bit_cnt_reg <= 4'h0;
							state_reg   <= ST_RX;
							if (kind_reg != `KIND_DATA) begin
								kind_reg <= kind_reg + 1'b1;
							end
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == `WORD_BITS) begin
							sda_oe_n  <= 1'b1;
							state_reg <= ST_RACK;
						end else begin
							sda_oe_n    <= shift_reg[6];
							shift_reg   <= {shift_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 1'b1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						host_ack_reg <= !sda_s;
					end else if (scl_fall) begin
						if (host_ack_reg) begin
							shift_reg   <= rd_byte;
							addr_reg    <= addr_inc;
							sda_oe_n    <= rd_byte[7];
							bit_cnt_reg <= 4'h1;
							state_reg   <= ST_TX;
						end else begin
							// No acknowledge: wait idle for the stop.
							state_reg <= ST_IDLE;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule

// file: hw/eeprom_consts.vh
// Purpose: Shared constants of the two-wire serial memory target.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only; the guard stops a second inclusion.
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// Reference clock rate in hertz.
`define REF_CLK_HZ        20000000

// Longest self-timed program cycle, in milliseconds.
`define PROG_TIME_MS      5

// Program cycle in reference clocks; a longest time rounds down.
`define PROG_CYCLES       ((`PROG_TIME_MS * `REF_CLK_HZ) / 1000)

// Width of the program cycle counter, enough for the default count.
`define PROG_CNT_W        17

// Word address widths of the smaller and the larger variant.
`define ADDR_W_SMALL      12
`define ADDR_W_LARGE      13

// Bytes per page as a number of low address bits.
`define PAGE_BITS         5
`define PAGE_BYTES        32

// Bits per transferred word.
`define WORD_BITS         8

// Device-type code; the value is arbitrary.
`define DEV_TYPE_DEFAULT  4'h5

// Kinds of received byte.
`define KIND_DEV          2'h0
`define KIND_ADDR_HI      2'h1
`define KIND_ADDR_LO      2'h2
`define KIND_DATA         2'h3

// Reset value of the synchronised pins {wp, straps, sda, scl}.
`define PIN_RESET_VAL     6'h03

`endif

// file: hw/pin_sync.v
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Each bit is independent; no multi-bit coherence is needed.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ns
module pin_sync #(
	parameter         WIDTH     = 6,
	parameter [5:0]   RESET_VAL = 6'h03
) (
	input  wire               ref_clk,
	input  wire               arst_n,
	input  wire [WIDTH-1:0]   pins,
	output reg  [WIDTH-1:0]   synced
);

	reg [WIDTH-1:0] meta_reg;

	// Both stages reset to the idle level of the bus lines.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= RESET_VAL[WIDTH-1:0];
			synced   <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta_reg <= pins;
			synced   <= meta_reg;
		end
	end

endmodule

// file: hw/program_timer.v
// Purpose: Self-timed program cycle counter.
// Assumes: start is a one-cycle pulse from the same clock domain.
// Notes:   busy rises on the edge after start and stays for CYCLES clocks.
`timescale 1ns/1ns
`include "eeprom_consts.vh"
module program_timer #(
	parameter         CNT_W  = `PROG_CNT_W,
	parameter         CYCLES = `PROG_CYCLES
) (
	input  wire               ref_clk,
	input  wire               arst_n,
	input  wire               start,
	output reg                busy
);

	reg [CNT_W-1:0] cnt_reg;

	// Load CYCLES minus one on start and run down to zero.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= {CNT_W{1'b0}};
			busy    <= 1'b0;
		end else if (start) begin
			cnt_reg <= CYCLES[CNT_W-1:0] - 1'b1;
			busy    <= 1'b1;
		end else if (cnt_reg != {CNT_W{1'b0}}) begin
			cnt_reg <= cnt_reg - 1'b1;
		end else begin
			busy    <= 1'b0;
		end
	end

endmodule

// file: verification/serial_eeprom_properties.sv
// Purpose: Port-level checks of the two-wire memory target.
// Assumes: One ref_clk domain; the bench drives the serial pins slowly.
// Notes:   Bound to every serial_eeprom instance.
`timescale 1ns/1ns
module serial_eeprom_properties #(
	parameter PROG_CYCLES = 200
) (
	input wire ref_clk,
	input wire arst_n,
	input wire scl_pin,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire strap_bit_high,
	input wire strap_bit_mid,
	input wire strap_bit_low,
	input wire write_protect,
	input wire program_busy,
	input wire standby
);
	reg [31:0] run_reg;

	// Length of the busy run; a counter avoids a long repetition.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			run_reg <= 32'h0;
		else if (program_busy)
			run_reg <= run_reg + 32'h1;
		else
			run_reg <= 32'h0;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence busy_tail;
		program_busy ##1 !program_busy;
	endsequence

	chk_open_drain:
	assert property (sda_out == 1'b0) else $error("Data output not low.");
	chk_busy_quiet:
	assert property (program_busy |-> sda_oe_n)
		else $error("Device drove the bus while busy.");
	chk_busy_awake:
	assert property (program_busy |-> !standby)
		else $error("Standby shown while busy.");
	chk_standby_back:
	assert property (busy_tail |-> ##[0:2] standby)
		else $error("No standby after programming.");
	chk_busy_length:
	assert property ($fell(program_busy) |-> run_reg == PROG_CYCLES)
		else $error("Program cycle length wrong.");
	chk_protect_idle:
	assert property ($rose(program_busy) |-> !$past(write_protect, 8))
		else $error("Programming while protected.");
	chk_prog_on_stop:
	assert property ($rose(program_busy) |->
		scl_pin && $past(sda_in, 3) && !$past(sda_in, 8))
		else $error("Programming began without a stop.");
	chk_drive_clk_low:
	assert property ($changed(sda_oe_n) |-> !$past(scl_pin))
		else $error("Data drive changed with clock high.");
endmodule

bind serial_eeprom serial_eeprom_properties #(
	.PROG_CYCLES(PROG_CYCLES)
) u_props (
	.ref_clk(ref_clk), .arst_n(arst_n), .scl_pin(scl_pin),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.strap_bit_high(strap_bit_high), .strap_bit_mid(strap_bit_mid),
	.strap_bit_low(strap_bit_low), .write_protect(write_protect),
	.program_busy(program_busy), .standby(standby)
);

// file: verification/bus_controller_model.sv
// Purpose: Behavioural two-wire bus controller for the bench.
// Assumes: Callers enter each task just after a ref_clk edge.
// Notes:   Clock bit period is eight ref_clk cycles, 400 ns.
`timescale 1ns/1ns
module bus_controller_model (
	input  wire  ref_clk,
	input  wire  sda_line,
	output logic scl,
	output logic sda_drv
);
	// The clock rests high between frames, as the pull-up leaves it.
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Data moves only with the clock low; sampled halfway through the high phase.
	task automatic bit_io(input b, output r);
		sda_drv <= b;
		tick(2);
		scl <= 1'b1;
		tick(2);
		r = sda_line;
		tick(2);
		scl <= 1'b0;
		tick(2);
	endtask

	task automatic byte_io(input [7:0] d, input a_in,
			output [7:0] q, output a_out);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], b);
			q[i] = b;
		end
		bit_io(a_in, a_out);
	endtask

	// Clock up to nine times until the line is seen released.
	task automatic recover();
		sda_drv <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			scl <= 1'b0;
			tick(4);
			scl <= 1'b1;
			tick(4);
			if (sda_line)
				break;
		end
	endtask

	// Release the data line and wait four ticks before raising the clock.
	task automatic start_cond();
		sda_drv <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b0;
		tick(2);
	endtask

	task automatic stop_cond();
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b1;
		tick(8);
	endtask
endmodule

// file: verification/serial_eeprom_bench.sv
// Purpose: Self-checking bench of the two-wire memory target.
// Assumes: Straps 3'h5; a short program cycle stands in for the real one.
// Notes:   The line has a pull-up; either party can only pull low.
`timescale 1ns/1ns
module serial_eeprom_bench;
	localparam [3:0] DEV_TYPE = 4'h5; // Arbitrary type code.
	localparam int PROG = 200;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic wp = 1'b0;
	logic [2:0] straps = 3'h5;
	wire scl;
	wire sda_drv;
	wire sda_out;
	wire sda_oe_n;
	wire program_busy;
	wire standby;
	wire sda_line = sda_drv & (sda_oe_n | sda_out);
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	serial_eeprom #(.ADDR_W(13), .DEVICE_TYPE(DEV_TYPE),
		.PROG_CYCLES(PROG)) u_dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .scl_pin(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.strap_bit_high(straps[2]), .strap_bit_mid(straps[1]),
		.strap_bit_low(straps[0]), .write_protect(wp),
		.program_busy(program_busy), .standby(standby));
	bus_controller_model u_ctl (.ref_clk(ref_clk), .sda_line(sda_line),
		.scl(scl), .sda_drv(sda_drv));

	always #25 ref_clk = ~ref_clk;

	task complete_run;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// A hang ends the run as a failure.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			complete_run;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic [7:0] dev_word(input rw);
		dev_word = {DEV_TYPE, straps, rw};
	endfunction

	task automatic send(input [7:0] d, input exp_ack);
		logic [7:0] q;
		logic a;
		u_ctl.byte_io(d, 1'b1, q, a);
		check(a, exp_ack);
	endtask

	task automatic addr_phase(input [15:0] a);
		send(dev_word(1'b0), 1'b0);
		send(a[15:8], 1'b0);
		send(a[7:0], 1'b0);
	endtask

	task automatic write_mem(input [15:0] a, input int n, input [7:0] b);
		u_ctl.start_cond();
		addr_phase(a);
		for (int i = 0; i < n; i++)
			send(b + i[7:0], 1'b0);
		u_ctl.stop_cond();
	endtask

	task automatic read_seq(input rnd, input [15:0] a, input int n,
			input [7:0] b);
		logic [7:0] q;
		logic x;
		if (rnd) begin
			u_ctl.start_cond();
			addr_phase(a);
		end
		u_ctl.start_cond();
		send(dev_word(1'b1), 1'b0);
		for (int i = 0; i < n; i++) begin
			u_ctl.byte_io(8'hFF, i == n - 1, q, x);
			check(q, b + i[7:0]);
		end
		u_ctl.stop_cond();
	endtask

	task automatic wait_busy(input v, input int lim);
		int k;
		k = 0;
		while (program_busy !== v && k < lim) begin
			@(posedge ref_clk);
			k++;
		end
		check(program_busy, v);
	endtask

	// Main sequence; the first check waits for the synchroniser fill after reset release.
	initial begin
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check({sda_oe_n, standby, program_busy}, 3'h6);
		u_ctl.recover();
		for (int i = 3; i < 7; i++) begin
			u_ctl.start_cond();
			send(dev_word(1'b0) ^ (8'h80 >> i), 1'b1);
			u_ctl.stop_cond();
		end
		write_mem(16'hE000, 1, 8'h5A);
		wait_busy(1'b1, 10);
		check(standby, 1'b0);
		u_ctl.start_cond();
		send(dev_word(1'b0), 1'b1);
		u_ctl.stop_cond();
		wait_busy(1'b0, PROG);
		u_ctl.start_cond();
		send(dev_word(1'b0), 1'b0);
		u_ctl.stop_cond();
		write_mem(16'h1FFE, 34, 8'h10);
		wait_busy(1'b1, 10);
		wait_busy(1'b0, PROG + 10);
		read_seq(1'b1, 16'h1FE0, 32, 8'h12);
		read_seq(1'b0, 16'h0000, 1, 8'h5A);
		wp <= 1'b1;
		write_mem(16'h1FE0, 1, 8'hEE);
		repeat (20) @(posedge ref_clk);
		check(program_busy, 1'b0);
		read_seq(1'b1, 16'h1FE0, 1, 8'h12);
		complete_run;
	end
endmodule
